/* File: stall_pkg.sv */
// Constants and types shared by the stall control and its write buffer
package stall_pkg;
	localparam logic [7:0] MICRO_PENALTY   = 8'h01;
	localparam logic [7:0] MAIN_PENALTY    = 8'h0D;
	localparam logic [7:0] PARTIAL_PENALTY = 8'h01;
	localparam int         READ_LATENCY    = 5;
	localparam int         I_REFILL_WORDS  = 4;
	localparam int         D_REFILL_WORDS  = 1;
	localparam int         WB_DEPTH        = 1;
	localparam int         MICRO_ENTRIES   = 2;
	localparam int         MAIN_ENTRIES    = 56;
	localparam logic [5:0] RANDOM_RESET    = 6'h2A;
	localparam logic [5:0] RANDOM_TAPS     = 6'h30;
	localparam logic [7:0] COUNT_RESET     = 8'h00;

	typedef enum logic [1:0] {
		REFILL_IDLE,
		REFILL_LATENCY,
		REFILL_WORDS
	} refill_state_type;
endpackage

/* File: wb_link.sv */
// Signals between the stall control and its write buffer
`timescale 1ns/10ps
`default_nettype none
interface wb_link;
	logic        push;
	logic [31:0] push_addr;
	logic [31:0] push_data;
	logic [3:0]  push_be;
	logic        gather;
	logic        bus_busy;
	logic        full;
	logic        mem_write;
	logic [31:0] mem_addr;
	logic [31:0] mem_data;
	logic [3:0]  mem_be;
	logic        mem_done;

	modport ctrl (output push, push_addr, push_data, push_be, gather, bus_busy, mem_done,
		input full, mem_write, mem_addr, mem_data, mem_be);
	modport buffer (input push, push_addr, push_data, push_be, gather, bus_busy, mem_done,
		output full, mem_write, mem_addr, mem_data, mem_be);
endinterface
`default_nettype wire

/* File: write_buffer.sv */
// Write buffer with byte gathering and idle-bus draining
`timescale 1ns/10ps
`default_nettype none
module write_buffer #(
	parameter int DEPTH = stall_pkg::WB_DEPTH
) (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	wb_link.buffer    link
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [IW:0] DEPTH_N = (IW+1)'(DEPTH);

	logic [31:0]   addr [DEPTH];
	logic [31:0]   data [DEPTH];
	logic [3:0]    be   [DEPTH];
	logic [IW:0]   count;
	logic [IW-1:0] head;
	logic          hit;
	logic [IW-1:0] hit_idx;

	function automatic logic [IW-1:0] wrap(input logic [IW-1:0] base, input logic [IW:0] off);
		logic [IW:0] s;
		s = (IW+1)'(base) + off;
		if (s >= DEPTH_N)
			s = s - DEPTH_N;
		return s[IW-1:0];
	endfunction

	// Head entry starts its memory write this cycle
	wire logic launch = !link.mem_write && count != '0 && !link.bus_busy;

	// Merge target: a stored entry with the same address, not one on or entering the bus
	always_comb begin
		hit     = 1'b0;
		hit_idx = '0;
		for (int k = 0; k < DEPTH; k++) begin
			if (link.gather && (IW+1)'(k) < count && addr[wrap(head, (IW+1)'(k))] == link.push_addr
				&& !(k == 0 && (link.mem_write || launch))) begin
				hit     = 1'b1;
				hit_idx = wrap(head, (IW+1)'(k));
			end
		end
	end

	wire logic retire = link.mem_write && link.mem_done;
	// A retiring entry frees its slot in the same cycle, so use the full flag
	wire logic append = link.push && !hit && !link.full;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int k = 0; k < DEPTH; k++) begin
				addr[k] <= 32'h00000000;
				data[k] <= 32'h00000000;
				be[k]   <= 4'h0;
			end
		end else if (link.push && hit) begin
			for (int b = 0; b < 4; b++)
				if (link.push_be[b])
					data[hit_idx][8*b +: 8] <= link.push_data[8*b +: 8];
			be[hit_idx] <= be[hit_idx] | link.push_be;
		end else if (append) begin
			addr[wrap(head, count)] <= link.push_addr;
			data[wrap(head, count)] <= link.push_data;
			be[wrap(head, count)]   <= link.push_be;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= '0;
			head  <= '0;
		end else begin
			count <= count + (IW+1)'(append) - (IW+1)'(retire);
			if (retire)
				head <= wrap(head, (IW+1)'(1));
		end
	end

	assign link.full = (count == DEPTH_N) && !retire;

	// Drain whenever data waits and no refill owns the bus
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link.mem_write <= 1'b0;
			link.mem_addr  <= 32'h00000000;
			link.mem_data  <= 32'h00000000;
			link.mem_be    <= 4'h0;
		end else if (link.mem_write) begin
			if (link.mem_done)
				link.mem_write <= 1'b0;
		end else if (launch) begin
			link.mem_write <= 1'b1;
			link.mem_addr  <= addr[head];
			link.mem_data  <= data[head];
			link.mem_be    <= be[head];
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_drain_idle_bus: assert property (count != '0 && !link.bus_busy && !link.mem_write
		|=> link.mem_write) else $error("buffer did not drain on idle bus");
	a_refill_holds_writes: assert property (link.bus_busy && !link.mem_write
		|=> !link.mem_write) else $error("write started during refill");
	a_merge_no_growth: assert property (link.push && hit && !retire
		|=> count == $past(count)) else $error("merge added an entry");
	c_merge: cover property (link.push && hit);
endmodule // write_buffer
`default_nettype wire

/* File: cpu_memory_stall_control.sv */
// Pipeline stall, instruction streaming and refill control
`timescale 1ns/10ps
`default_nettype none
module cpu_memory_stall_control #(
	parameter int READ_LATENCY = stall_pkg::READ_LATENCY,
	parameter int I_WORDS      = stall_pkg::I_REFILL_WORDS,
	parameter int D_WORDS      = stall_pkg::D_REFILL_WORDS,
	parameter int WB_DEPTH     = stall_pkg::WB_DEPTH
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        stream_enable_i,
	input  wire logic        gather_enable_i,
	input  wire logic        icache_miss_i,
	input  wire logic        dcache_miss_i,
	input  wire logic        micro_miss_i,
	input  wire logic        micro_hit_i,
	input  wire logic        micro_hit_way_i,
	input  wire logic        main_miss_i,
	input  wire logic        branch_i,
	input  wire logic        store_i,
	input  wire logic        partial_store_i,
	input  wire logic [31:0] store_addr_i,
	input  wire logic [31:0] store_data_i,
	input  wire logic [3:0]  store_be_i,
	input  wire logic        mem_write_done_i,
	output logic             stall_o,
	output logic             streaming_o,
	output logic             refill_read_o,
	output logic             refill_word_o,
	output logic             refill_data_o,
	output logic             micro_replace_way_o,
	output logic [5:0]       main_replace_index_o,
	output logic             mem_write_o,
	output logic [31:0]      mem_write_addr_o,
	output logic [31:0]      mem_write_data_o,
	output logic [3:0]       mem_write_be_o
);
	localparam logic [7:0] LAT_LAST = 8'(READ_LATENCY - 1);
	localparam logic [7:0] I_LAST   = 8'(I_WORDS - 1);
	localparam logic [7:0] D_LAST   = 8'(D_WORDS - 1);

	wb_link link ();

	stall_pkg::refill_state_type state;
	stall_pkg::refill_state_type next_state;
	logic [7:0]  cnt;
	logic [7:0]  next_cnt;
	logic [7:0]  pen;
	logic [7:0]  next_pen;
	logic        kind_i;
	logic        next_kind_i;
	logic        stream_ok;
	logic        next_stream_ok;
	logic        dpend;
	logic        next_dpend;
	logic        pend_store;
	logic        next_pend_store;
	logic [31:0] pend_addr;
	logic [31:0] pend_data;
	logic [3:0]  pend_be;
	logic        streaming;
	logic        leave;
	logic        take;
	logic [5:0]  rnd;

	function automatic logic streams(input stall_pkg::refill_state_type s, input logic ki,
		input logic ok);
		return s == stall_pkg::REFILL_WORDS && ki && ok;
	endfunction

	assign streaming = streams(state, kind_i, stream_ok);
	assign leave = streaming && (branch_i || dcache_miss_i || partial_store_i
		|| (store_i && link.full));
	assign take = !stall_o && !leave;

	always_comb begin
		next_state      = state;
		next_cnt        = cnt;
		next_kind_i     = kind_i;
		next_stream_ok  = stream_ok && !leave;
		next_dpend      = dpend || (take && dcache_miss_i && (state != stall_pkg::REFILL_IDLE
			|| icache_miss_i));
		next_pen        = (pen != 8'h00) ? pen - 8'h01 : 8'h00;
		next_pend_store = pend_store ? link.full : (take && store_i && link.full);
		if (take) begin
			if (micro_miss_i)
				next_pen = next_pen + stall_pkg::MICRO_PENALTY;
			if (main_miss_i)
				next_pen = next_pen + stall_pkg::MAIN_PENALTY;
			if (partial_store_i)
				next_pen = next_pen + stall_pkg::PARTIAL_PENALTY;
		end
		case (state)
			stall_pkg::REFILL_IDLE: begin
				if (take && icache_miss_i) begin
					next_state     = stall_pkg::REFILL_LATENCY;
					next_kind_i    = 1'b1;
					next_stream_ok = stream_enable_i;
					next_cnt       = LAT_LAST;
				end else if (dpend || (take && dcache_miss_i)) begin
					next_state  = stall_pkg::REFILL_LATENCY;
					next_kind_i = 1'b0;
					next_dpend  = 1'b0;
					next_cnt    = LAT_LAST;
				end
			end
			stall_pkg::REFILL_LATENCY: begin
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h00) begin
					next_state = stall_pkg::REFILL_WORDS;
					next_cnt   = kind_i ? I_LAST : D_LAST;
				end
			end
			stall_pkg::REFILL_WORDS: begin
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h00)
					next_state = stall_pkg::REFILL_IDLE;
			end
			default: begin
				next_state = stall_pkg::REFILL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state      <= stall_pkg::REFILL_IDLE;
			cnt        <= stall_pkg::COUNT_RESET;
			pen        <= stall_pkg::COUNT_RESET;
			kind_i     <= 1'b0;
			stream_ok  <= 1'b0;
			dpend      <= 1'b0;
			pend_store <= 1'b0;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			pen        <= next_pen;
			kind_i     <= next_kind_i;
			stream_ok  <= next_stream_ok;
			dpend      <= next_dpend;
			pend_store <= next_pend_store;
		end
	end

	// Registered view of the next cycle's stall and refill status
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stall_o       <= 1'b0;
			streaming_o   <= 1'b0;
			refill_read_o <= 1'b0;
			refill_word_o <= 1'b0;
			refill_data_o <= 1'b0;
		end else begin
			stall_o <= next_pen != 8'h00 || next_pend_store || next_dpend
				|| (next_state != stall_pkg::REFILL_IDLE
				&& !streams(next_state, next_kind_i, next_stream_ok));
			streaming_o   <= streams(next_state, next_kind_i, next_stream_ok);
			refill_read_o <= next_state != stall_pkg::REFILL_IDLE;
			refill_word_o <= next_state == stall_pkg::REFILL_WORDS;
			refill_data_o <= !next_kind_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_addr <= 32'h00000000;
			pend_data <= 32'h00000000;
			pend_be   <= 4'h0;
		end else if (take && store_i && link.full) begin
			pend_addr <= store_addr_i;
			pend_data <= store_data_i;
			pend_be   <= store_be_i;
		end
	end

	assign link.push      = pend_store ? !link.full : (take && store_i && !link.full);
	assign link.push_addr = pend_store ? pend_addr : store_addr_i;
	assign link.push_data = pend_store ? pend_data : store_data_i;
	assign link.push_be   = pend_store ? pend_be : store_be_i;
	assign link.gather    = gather_enable_i;
	// A refill starting this cycle already owns the bus
	assign link.bus_busy  = state != stall_pkg::REFILL_IDLE
		|| next_state != stall_pkg::REFILL_IDLE;
	assign link.mem_done  = mem_write_done_i;

	write_buffer #(.DEPTH(WB_DEPTH)) u_buffer (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.link      (link.buffer)
	);

	assign mem_write_o      = link.mem_write;
	assign mem_write_addr_o = link.mem_addr;
	assign mem_write_data_o = link.mem_data;
	assign mem_write_be_o   = link.mem_be;

	// Micro entry replacement and random main entry pick
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			micro_replace_way_o <= 1'b0;
		end else if (take && micro_miss_i) begin
			micro_replace_way_o <= !micro_replace_way_o;
		end else if (micro_hit_i) begin
			micro_replace_way_o <= !micro_hit_way_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rnd <= stall_pkg::RANDOM_RESET;
		else
			rnd <= {rnd[4:0], ^(rnd & stall_pkg::RANDOM_TAPS)};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			main_replace_index_o <= 6'h00;
		else if (take && main_miss_i)
			main_replace_index_o <= (rnd >= 6'(stall_pkg::MAIN_ENTRIES))
				? rnd - 6'(stall_pkg::MAIN_ENTRIES) : rnd;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_micro_penalty: assert property (take && micro_miss_i && !main_miss_i && !partial_store_i
		|=> stall_o && pen == 8'h01) else $error("micro miss penalty not one");
	a_main_penalty: assert property (take && main_miss_i && !micro_miss_i && !partial_store_i
		|=> pen == 8'h0D ##12 pen == 8'h01 ##1 pen == 8'h00) else $error("main miss penalty wrong");
	a_partial_penalty: assert property (take && partial_store_i && !micro_miss_i && !main_miss_i
		|=> pen == 8'h01) else $error("partial store penalty wrong");
	a_single_stall: assert property (pen != 8'h00 || pend_store |-> stall_o)
		else $error("penalty pending without stall");
	a_dmiss_length: assert property (state == stall_pkg::REFILL_IDLE && !dpend && take
		&& dcache_miss_i && !icache_miss_i |=> refill_read_o [*6] ##1 !refill_read_o)
		else $error("data miss refill length wrong");
	a_branch_exit: assert property (streaming && branch_i |=> !stream_ok && stall_o)
		else $error("branch did not leave streaming");
	a_load_exit: assert property (streaming && dcache_miss_i |=> !streaming_o)
		else $error("load miss did not abort streaming");
	a_write_exit: assert property (streaming && (partial_store_i || (store_i && link.full))
		|=> !streaming_o) else $error("write did not leave streaming");
	a_refill_continues: assert property (leave && cnt != 8'h00
		|=> state == stall_pkg::REFILL_WORDS && refill_word_o) else $error("refill cancelled");
	a_stream_issue: assert property (streaming && pen == 8'h00 && !dpend |-> !stall_o)
		else $error("stall while streaming");
	a_iblock_words: assert property (state == stall_pkg::REFILL_LATENCY && cnt == 8'h00 && kind_i
		|=> refill_word_o [*4] ##1 !refill_word_o) else $error("instruction block size wrong");
	a_full_stall: assert property (pend_store |-> stall_o && !take)
		else $error("full buffer write not stalled");

	c_stream_full_block: cover property (streaming && cnt == 8'h00 && !leave);
	c_stream_branch_exit: cover property (streaming && branch_i);
	c_full_buffer_wait: cover property (pend_store ##1 !pend_store);
endmodule // cpu_memory_stall_control
`default_nettype wire

/* File: page_memory_model.sv */
// Page-mode main memory that answers buffered writes
`timescale 1ns/10ps
`default_nettype none
module page_memory_model #(
	parameter int PAGE_BITS = 10,
	parameter int IDLE_CYC  = 5,
	parameter int PAGE_CYC  = 2,
	parameter int MISS_CYC  = 6
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        write_i,
	input  wire logic [31:0] addr_i,
	input  wire logic        slow_i,
	output var logic         done_o
);
	int          left;
	int          gap;
	logic        busy;
	logic [31:0] last;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done_o <= 1'b0;
			busy <= 1'b0;
			left <= 0;
			gap <= 99;
			last <= 32'h00000000;
		end else begin
			done_o <= 1'b0;
			if (!busy) gap <= gap + 1;
			if (done_o) begin
				busy <= 1'b0;
				gap <= 0;
			end else if (write_i === 1'b1 && !busy) begin
				busy <= 1'b1;
				last <= addr_i;
				// Isolated, same-page and other-page service times
				left <= (gap > 1 ? IDLE_CYC : (addr_i[31:PAGE_BITS] == last[31:PAGE_BITS] ?
					PAGE_CYC : MISS_CYC)) + (slow_i ? 10 : 0) - 2;
			end else if (busy && left > 0) begin
				left <= left - 1;
			end else if (busy) begin
				done_o <= write_i;
			end
		end
	end
endmodule // page_memory_model
`default_nettype wire

/* File: cpu_memory_stall_control_bench.sv */
// Self-checking bench for the stall control
`timescale 1ns/10ps
`default_nettype none
module cpu_memory_stall_control_bench;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        stream_en = 1'b0;
	logic        gather_en = 1'b0;
	logic        slow = 1'b0;
	logic [7:0]  ev = 8'h00;
	logic        st = 1'b0;
	logic [31:0] sa = 32'h00000000;
	logic [31:0] sd = 32'h00000000;
	logic [3:0]  sbe = 4'hF;
	logic        done, stall, strm, rd, word, rdata, way, mw, pmw, pdone;
	logic [5:0]  idx;
	logic [31:0] ma, md, pa;
	logic [3:0]  mbe;
	logic [67:0] wq[$];
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          nr = 0;
	int          nw = 0;

	always #2.5 clk = ~clk;

	// Event bits: 0 imiss 1 dmiss 2 micro miss 3 micro hit 4 hit way 5 main miss 6 branch 7 partial
	// Two entries, so a same-address store can merge behind the one on the bus
	cpu_memory_stall_control #(.WB_DEPTH(2)) u_cpu_memory_stall_control (.clk_i(clk),
		.reset_n_i(reset_n),
		.stream_enable_i(stream_en), .gather_enable_i(gather_en), .icache_miss_i(ev[0]),
		.dcache_miss_i(ev[1]), .micro_miss_i(ev[2]), .micro_hit_i(ev[3]),
		.micro_hit_way_i(ev[4]), .main_miss_i(ev[5]), .branch_i(ev[6]), .store_i(st),
		.partial_store_i(ev[7]), .store_addr_i(sa), .store_data_i(sd), .store_be_i(sbe),
		.mem_write_done_i(done), .stall_o(stall), .streaming_o(strm), .refill_read_o(rd),
		.refill_word_o(word), .refill_data_o(rdata), .micro_replace_way_o(way),
		.main_replace_index_o(idx), .mem_write_o(mw), .mem_write_addr_o(ma),
		.mem_write_data_o(md), .mem_write_be_o(mbe));

	page_memory_model u_page_memory_model (.clk_i(clk), .reset_n_i(reset_n), .write_i(mw),
		.addr_i(ma), .slow_i(slow), .done_o(done));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		nr += (rd === 1'b1);
		nw += (word === 1'b1);
		if (mw === 1'b1 && done === 1'b1) wq.push_back({mbe, ma, md});
		if (pmw && !pdone) chk(ma, pa);
		if (mw === 1'b1 && !pmw) chk(rd, 0);
		pmw <= (mw === 1'b1);
		pdone <= (done === 1'b1);
		pa <= ma;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// Present one instruction until an edge with the pipeline free takes it
	task automatic issue(input logic [7:0] e, input logic s);
		ev = e;
		st = s;
		while (stall !== 1'b0) tick();
		tick();
		ev = 8'h00;
		st = 1'b0;
	endtask

	task automatic run_len(output int n);
		n = 0;
		while (stall === 1'b1 && n < 100) begin
			n++;
			tick();
		end
	endtask

	task automatic wait_w(input int k);
		int i;
		for (i = 0; i < 300 && wq.size() < k; i++) tick();
	endtask

	task automatic t_penalty();
		int n;
		issue(8'h04, 1'b0);
		run_len(n);
		chk(n, 1);
		chk(way, 1);
		issue(8'h18, 1'b0);
		chk(stall, 0);
		chk(way, 0);
		issue(8'h20, 1'b0);
		run_len(n);
		chk(n, 13);
		chk(idx < 6'h38, 1);
		issue(8'h24, 1'b0);
		run_len(n);
		chk(n, 14);
		issue(8'h80, 1'b1);
		run_len(n);
		chk(n, 1);
		nr = 0;
		issue(8'h02, 1'b0);
		chk(rdata, 1);
		run_len(n);
		chk(n, 6);
		chk(nr, 6);
		nw = 0;
		issue(8'h01, 1'b0);
		run_len(n);
		chk(n, 9);
		chk(nw, 4);
	endtask

	task automatic t_stream();
		int n;
		stream_en = 1'b1;
		nr = 0;
		nw = 0;
		wq.delete();
		issue(8'h01, 1'b0);
		run_len(n);
		chk(n, 5);
		chk(strm, 1);
		issue(8'h00, 1'b1);
		chk(stall, 0);
		for (n = 0; n < 20 && strm === 1'b1; n++) tick();
		tick();
		chk(nw, 4);
		chk(nr, 9);
		wait_w(1);
		chk(wq.size(), 1);
	endtask

	task automatic t_exit(input logic [7:0] e);
		int n;
		stream_en = 1'b1;
		nw = 0;
		issue(8'h01, 1'b0);
		run_len(n);
		ev = e;
		st = e[7];
		tick();
		ev = 8'h00;
		st = 1'b0;
		chk(strm, 0);
		chk(stall, 1);
		run_len(n);
		chk(nw, 4);
		chk(word, 0);
		issue(e, e[7]);
		run_len(n);
		repeat (20) tick();
	endtask

	task automatic t_buffer();
		int n;
		stream_en = 1'b0;
		wq.delete();
		sa = 32'h00001000;
		sd = 32'hA5A5A5A5;
		issue(8'h00, 1'b1);
		sa = 32'h00008000;
		sd = 32'h5A5A5A5A;
		issue(8'h00, 1'b1);
		issue(8'h00, 1'b1);
		run_len(n);
		chk(n != 0, 1);
		wait_w(3);
		chk(wq.size(), 3);
		chk(wq[2][63:32], 32'h00008000);
		chk(wq[0][63:32], 32'h00001000);
		chk(wq[1][63:32], 32'h00008000);
		chk(wq[1][31:0], 32'h5A5A5A5A);
		repeat (20) tick();
		wq.delete();
		gather_en = 1'b1;
		slow = 1'b1;
		issue(8'h00, 1'b1);
		sa = 32'h00000100;
		sd = 32'h00000011;
		sbe = 4'h1;
		issue(8'h00, 1'b1);
		sd = 32'h00002200;
		sbe = 4'h2;
		issue(8'h00, 1'b1);
		run_len(n);
		wait_w(2);
		repeat (60) tick();
		chk(wq.size(), 2);
		chk(wq[1][67:64], 4'h3);
		chk(wq[1][31:0], 32'h00002211);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		reset_n = 1'b1;
		tick();
		t_penalty();
		t_stream();
		t_exit(8'h40);
		t_exit(8'h02);
		t_exit(8'h80);
		t_buffer();
		conclude();
	end
endmodule // cpu_memory_stall_control_bench
`default_nettype wire
